// *** core/t1irq_pkg.sv ***
/*
 * Package for the timer interrupt flag and mask block: register indices,
 * field positions, reset values, waveform mode codes and the bus carrier.
 * Assumes a plain register port with an 8-bit data path.
 */
package t1irq_pkg;

	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 8;

	localparam logic [3:0]  OFF_MASK        = 4'h0;
	localparam logic [3:0]  OFF_FLAGS       = 4'h1;
	localparam logic [3:0]  OFF_STATUS      = 4'h2;
	localparam logic [3:0]  OFF_IRQ_CLR     = 4'h3;
	localparam logic [3:0]  OFF_IRQ_EN      = 4'h4;
	localparam logic [3:0]  OFF_CTRL        = 4'h5;

	localparam int          BIT_OVF         = 0;
	localparam int          BIT_MATCH_A     = 1;
	localparam int          BIT_MATCH_B     = 2;
	localparam int          BIT_CAPTURE     = 5;
	localparam int          CTRL_EDGE_BIT   = 0;
	localparam int          CTRL_WGM_LSB    = 4;

	localparam logic [7:0]  FLAG_MASK       = 8'h27;
	localparam logic [7:0]  MASK_RESET      = 8'h00;
	localparam logic [7:0]  FLAGS_RESET     = 8'h00;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [3:0]  STAT_MASK       = 4'hF;

	localparam logic [3:0]  WGM_NORMAL      = 4'h0;
	localparam logic [3:0]  WGM_CTC_OCRA    = 4'h4;
	localparam logic [3:0]  WGM_CTC_ICR     = 4'hC;
	localparam logic [3:0]  WGM_FPWM_ICR    = 4'hE;
	localparam logic [3:0]  WGM_PC_ICR      = 4'hA;
	localparam logic [3:0]  WGM_PFC_ICR     = 4'h8;

	typedef enum logic [1:0] {
		EDGE_IDLE = 2'b00,
		EDGE_SEEN = 2'b01
	} edge_state_e;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;

	typedef struct packed {
		logic overflow;
		logic match_a;
		logic match_b;
		logic top_reached;
	} timer_evt_s;

	function automatic logic is_icr_top(input logic [3:0] wgm);
		is_icr_top = (wgm == WGM_CTC_ICR) || (wgm == WGM_FPWM_ICR) ||
		             (wgm == WGM_PC_ICR) || (wgm == WGM_PFC_ICR);
	endfunction : is_icr_top

endpackage : t1irq_pkg

// *** core/capture_edge.sv ***
/*
 * Capture pin conditioner: two-stage synchroniser and edge select.
 * Assumes the pin is asynchronous to mclk.
 */
`timescale 1ns/1ps
module capture_edge
	import t1irq_pkg::*;
(
	input  wire logic mclk,
	input  wire logic srst,
	input  wire logic ce,
	input  wire logic pin,
	input  wire logic rising_sel,
	input  wire logic disconnect,
	output logic      event_pulse
);
	logic sync1_r;
	logic sync2_r;
	logic prev_r;

	// The stages keep sampling through reset, so the detector leaves reset holding the
	// pin's real level and no false edge follows release; reset must last three edges.
	always_ff @(posedge mclk) begin
		if (srst || ce) begin
			sync1_r <= pin;
			sync2_r <= sync1_r;
		end
	end

	// The previous sample is taken from the second stage only.
	always_ff @(posedge mclk) begin
		if (srst || ce) begin
			prev_r <= sync2_r;
		end
	end

	// Edge choice and disconnect act on the synchronised level.
	always_comb begin
		if (disconnect) begin
			event_pulse = 1'b0;
		end else if (rising_sel) begin
			event_pulse = ce && sync2_r && !prev_r;
		end else begin
			event_pulse = ce && !sync2_r && prev_r;
		end
	end

endmodule : capture_edge

// *** core/t1irq_ctrl.sv ***
// What this block does
// - Capture request needs enable, global, flag.
// - Match B request needs enable, global, flag.
// - Match A request needs enable, global, flag.
// - Overflow request needs enable, global, flag.
// - Unused bits 7,6,4,3 read zero.
// - Capture pin event sets capture flag.
// - Capture-as-TOP mode sets flag at TOP.
// - Capture flag clears on vector or write-one.
// - Match B flag sets one cycle later.
// - Match A flag sets one cycle later.
// - Force strobes never set match flags.
// - Match B flag clears on vector or write-one.
// - Match A flag clears on vector or write-one.
// - Overflow flag set per waveform mode.
// - Overflow flag clears on vector or write-one.
// - Edge select picks falling or rising edge.
// - Capture pin ignored while capture is TOP.
//
// The placing of the registers and the strobed register port are this design's own decisions.
/*
 * Timer interrupt flag and mask registers with per-source requests,
 * plus a sticky event status, clear and enable group for one level line.
 * Assumes the counter datapath supplies one-cycle event pulses on mclk
 * and the CPU pulses one acknowledge bit per executed vector.
 */
`timescale 1ns/1ps
module t1irq_ctrl
	import t1irq_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 srst,
	input  wire logic                 ce,
	input  wire logic [ADDR_W-1:0]    addr,
	input  wire logic [DATA_W-1:0]    wdata,
	input  wire logic                 wr_stb,
	input  wire logic                 rd_stb,
	output logic      [DATA_W-1:0]    rdata,
	input  wire logic                 global_irq_en,
	input  wire logic                 ovf_evt,
	input  wire logic                 match_a_evt,
	input  wire logic                 match_b_evt,
	input  wire logic                 top_evt,
	input  wire logic                 force_match_a_strobe,
	input  wire logic                 force_match_b_strobe,
	input  wire logic                 capture_input_pin,
	input  wire logic [3:0]           vector_ack,
	output logic      [3:0]           irq_req,
	output logic                      irq
);
	bus_req_s    bus;
	timer_evt_s  evt;
	logic [7:0]  timer1_irq_mask_r;
	logic [7:0]  timer1_irq_flags_r;
	logic [7:0]  timer1_irq_flags_nxt;
	logic [7:0]  ctrl_r;
	logic [3:0]  status_r;
	logic [3:0]  irq_en_r;
	logic        match_a_d_r;
	logic        match_b_d_r;
	logic        capture_edge_pulse;
	logic        icr_top;
	logic [7:0]  set_vec;
	logic [7:0]  clr_vec;
	logic [3:0]  irq_req_nxt;
	logic        capture_set;

	assign bus = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};
	assign evt = '{overflow: ovf_evt, match_a: match_a_evt,
	               match_b: match_b_evt, top_reached: top_evt};
	assign icr_top = is_icr_top(ctrl_r[CTRL_WGM_LSB +: 4]);

	capture_edge u_capture_edge (
		.mclk        (mclk),
		.srst        (srst),
		.ce          (ce),
		.pin         (capture_input_pin),
		.rising_sel  (ctrl_r[CTRL_EDGE_BIT]),
		.disconnect  (icr_top),
		.event_pulse (capture_edge_pulse)
	);

	// Force strobes only steer the waveform unit, so they are left unread here.
	logic unused_force;
	assign unused_force = force_match_a_strobe | force_match_b_strobe;

	// Matches are delayed one cycle before they raise a flag.
	always_ff @(posedge mclk) begin
		if (srst) begin
			match_a_d_r <= 1'b0;
			match_b_d_r <= 1'b0;
		end else if (ce) begin
			match_a_d_r <= evt.match_a;
			match_b_d_r <= evt.match_b;
		end
	end

	assign capture_set = icr_top ? evt.top_reached : capture_edge_pulse;

	always_comb begin
		set_vec = 8'h00;
		set_vec[BIT_CAPTURE] = capture_set;
		set_vec[BIT_MATCH_B] = match_b_d_r;
		set_vec[BIT_MATCH_A] = match_a_d_r;
		// The counter reports overflow as the mode dictates, normal and CLEAR_ON_MATCH_MODE at wrap.
		set_vec[BIT_OVF] = evt.overflow;
		clr_vec = 8'h00;
		if (bus.wr && bus.addr == OFF_FLAGS) begin
			clr_vec = bus.wdata & FLAG_MASK;
		end
		clr_vec[BIT_OVF] = clr_vec[BIT_OVF] | vector_ack[0];
		clr_vec[BIT_MATCH_A] = clr_vec[BIT_MATCH_A] | vector_ack[1];
		clr_vec[BIT_MATCH_B] = clr_vec[BIT_MATCH_B] | vector_ack[2];
		clr_vec[BIT_CAPTURE] = clr_vec[BIT_CAPTURE] | vector_ack[3];
		timer1_irq_flags_nxt = ((timer1_irq_flags_r & ~clr_vec) | set_vec)
		                       & FLAG_MASK;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			timer1_irq_flags_r <= FLAGS_RESET;
		end else if (ce) begin
			timer1_irq_flags_r <= timer1_irq_flags_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			timer1_irq_mask_r <= MASK_RESET;
			ctrl_r            <= CTRL_RESET;
			irq_en_r          <= 4'h0;
		end else if (ce && bus.wr) begin
			case (bus.addr)
				OFF_MASK:   timer1_irq_mask_r <= bus.wdata & FLAG_MASK;
				OFF_CTRL:   ctrl_r <= bus.wdata;
				OFF_IRQ_EN: irq_en_r <= bus.wdata[3:0];
				default:    ctrl_r <= ctrl_r;
			endcase
		end
	end

	// Requests are registered so each output comes from a flip-flop.
	always_comb begin
		irq_req_nxt[0] = global_irq_en && timer1_irq_mask_r[BIT_OVF]
		                 && timer1_irq_flags_nxt[BIT_OVF];
		irq_req_nxt[1] = global_irq_en && timer1_irq_mask_r[BIT_MATCH_A]
		                 && timer1_irq_flags_nxt[BIT_MATCH_A];
		irq_req_nxt[2] = global_irq_en && timer1_irq_mask_r[BIT_MATCH_B]
		                 && timer1_irq_flags_nxt[BIT_MATCH_B];
		irq_req_nxt[3] = global_irq_en && timer1_irq_mask_r[BIT_CAPTURE]
		                 && timer1_irq_flags_nxt[BIT_CAPTURE];
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_req <= 4'h0;
		end else if (ce) begin
			irq_req <= irq_req_nxt;
		end
	end

	// Sticky status: same layout as irq_req; set wins over clear.
	logic [3:0] status_set;
	logic [3:0] status_clr;
	assign status_set = {set_vec[BIT_CAPTURE], set_vec[BIT_MATCH_B],
	                     set_vec[BIT_MATCH_A], set_vec[BIT_OVF]};
	assign status_clr = (bus.wr && bus.addr == OFF_IRQ_CLR) ? bus.wdata[3:0] : 4'h0;

	always_ff @(posedge mclk) begin
		if (srst) begin
			status_r <= 4'h0;
		end else if (ce) begin
			status_r <= ((status_r & ~status_clr) | status_set) & STAT_MASK;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |((((status_r & ~status_clr) | status_set)) & irq_en_r);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata <= 8'h00;
		end else if (ce) begin
			rdata <= 8'h00;
			if (bus.rd) begin
				case (bus.addr)
					OFF_MASK:   rdata <= timer1_irq_mask_r & FLAG_MASK;
					OFF_FLAGS:  rdata <= timer1_irq_flags_r & FLAG_MASK;
					OFF_STATUS: rdata <= {4'h0, status_r};
					OFF_IRQ_EN: rdata <= {4'h0, irq_en_r};
					OFF_CTRL:   rdata <= ctrl_r;
					default:    rdata <= 8'h00;
				endcase
			end
		end
	end

	sequence s_match_a_seen;
		(ce && match_a_evt) ##1 ce;
	endsequence

	property p_match_a_delay;
		@(posedge mclk) disable iff (srst)
		s_match_a_seen |=> timer1_irq_flags_r[BIT_MATCH_A];
	endproperty
	a_match_a_delay: assert property (p_match_a_delay)
		else $error("match A flag not set one cycle after match");

	sequence s_match_b_seen;
		(ce && match_b_evt) ##1 ce;
	endsequence

	property p_match_b_delay;
		@(posedge mclk) disable iff (srst)
		s_match_b_seen |=> timer1_irq_flags_r[BIT_MATCH_B];
	endproperty
	a_match_b_delay: assert property (p_match_b_delay)
		else $error("match B flag not set one cycle after match");

	property p_reserved_zero;
		@(posedge mclk) disable iff (srst)
		(timer1_irq_flags_r & ~FLAG_MASK) == 8'h00 && (timer1_irq_mask_r & ~FLAG_MASK) == 8'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bit set");

	property p_ovf_req;
		@(posedge mclk) disable iff (srst)
		$past(ce) && irq_req[0] |-> $past(global_irq_en && timer1_irq_mask_r[BIT_OVF])
		                            && timer1_irq_flags_r[BIT_OVF];
	endproperty
	a_ovf_req: assert property (p_ovf_req)
		else $error("overflow request without cause");

	property p_cap_req;
		@(posedge mclk) disable iff (srst)
		$past(ce) && irq_req[3] |-> $past(global_irq_en && timer1_irq_mask_r[BIT_CAPTURE])
		                            && timer1_irq_flags_r[BIT_CAPTURE];
	endproperty
	a_cap_req: assert property (p_cap_req)
		else $error("capture request without cause");

	property p_set_wins;
		@(posedge mclk) disable iff (srst)
		(ce && evt.overflow) |=> timer1_irq_flags_r[BIT_OVF];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("overflow set lost");

	property p_ack_clear;
		@(posedge mclk) disable iff (srst)
		(ce && vector_ack == 4'h1 && !set_vec[BIT_OVF]
		 && !(wr_stb && addr == OFF_FLAGS))
			|=> !timer1_irq_flags_r[BIT_OVF]
			    && timer1_irq_flags_r[BIT_MATCH_A] == ($past(timer1_irq_flags_r[BIT_MATCH_A])
			       | $past(set_vec[BIT_MATCH_A]));
	endproperty
	a_ack_clear: assert property (p_ack_clear)
		else $error("acknowledge clear wrong");

	property p_force_no_flag;
		@(posedge mclk) disable iff (srst)
		(ce && force_match_a_strobe && !match_a_d_r && !timer1_irq_flags_r[BIT_MATCH_A])
			|=> !timer1_irq_flags_r[BIT_MATCH_A];
	endproperty
	a_force_no_flag: assert property (p_force_no_flag)
		else $error("force strobe set match flag");

	property p_force_b_no_flag;
		@(posedge mclk) disable iff (srst)
		(ce && force_match_b_strobe && !match_b_d_r && !timer1_irq_flags_r[BIT_MATCH_B])
			|=> !timer1_irq_flags_r[BIT_MATCH_B];
	endproperty
	a_force_b_no_flag: assert property (p_force_b_no_flag)
		else $error("force strobe set match B flag");

	property p_match_a_req;
		@(posedge mclk) disable iff (srst)
		$past(ce) && irq_req[1] |-> $past(global_irq_en && timer1_irq_mask_r[BIT_MATCH_A])
		                            && timer1_irq_flags_r[BIT_MATCH_A];
	endproperty
	a_match_a_req: assert property (p_match_a_req)
		else $error("match A request without cause");

	property p_match_b_req;
		@(posedge mclk) disable iff (srst)
		$past(ce) && irq_req[2] |-> $past(global_irq_en && timer1_irq_mask_r[BIT_MATCH_B])
		                            && timer1_irq_flags_r[BIT_MATCH_B];
	endproperty
	a_match_b_req: assert property (p_match_b_req)
		else $error("match B request without cause");

	property p_req_raise;
		@(posedge mclk) disable iff (srst)
		(ce && global_irq_en && |(timer1_irq_mask_r & timer1_irq_flags_nxt)) |=> irq_req != 4'h0;
	endproperty
	a_req_raise: assert property (p_req_raise)
		else $error("enabled flag without request");

	property p_cap_top;
		@(posedge mclk) disable iff (srst)
		(ce && icr_top && top_evt) |=> timer1_irq_flags_r[BIT_CAPTURE];
	endproperty
	a_cap_top: assert property (p_cap_top)
		else $error("capture flag not set at top");

	property p_cap_disconnect;
		@(posedge mclk) disable iff (srst)
		(ce && icr_top && !top_evt && !timer1_irq_flags_r[BIT_CAPTURE])
			|=> !timer1_irq_flags_r[BIT_CAPTURE];
	endproperty
	a_cap_disconnect: assert property (p_cap_disconnect)
		else $error("capture flag set while pin disconnected");

	property p_wr_clear_cap;
		@(posedge mclk) disable iff (srst)
		(ce && wr_stb && addr == OFF_FLAGS && wdata[BIT_CAPTURE] && !set_vec[BIT_CAPTURE])
			|=> !timer1_irq_flags_r[BIT_CAPTURE];
	endproperty
	a_wr_clear_cap: assert property (p_wr_clear_cap)
		else $error("capture flag survived write-one clear");

	property p_wr_clear_b;
		@(posedge mclk) disable iff (srst)
		(ce && wr_stb && addr == OFF_FLAGS && wdata[BIT_MATCH_B] && !set_vec[BIT_MATCH_B])
			|=> !timer1_irq_flags_r[BIT_MATCH_B];
	endproperty
	a_wr_clear_b: assert property (p_wr_clear_b)
		else $error("match B flag survived write-one clear");

	property p_wr_clear_a;
		@(posedge mclk) disable iff (srst)
		(ce && wr_stb && addr == OFF_FLAGS && wdata[BIT_MATCH_A] && !set_vec[BIT_MATCH_A])
			|=> !timer1_irq_flags_r[BIT_MATCH_A];
	endproperty
	a_wr_clear_a: assert property (p_wr_clear_a)
		else $error("match A flag survived write-one clear");

	property p_ack_clear_cap;
		@(posedge mclk) disable iff (srst)
		(ce && vector_ack[3] && !set_vec[BIT_CAPTURE]) |=> !timer1_irq_flags_r[BIT_CAPTURE];
	endproperty
	a_ack_clear_cap: assert property (p_ack_clear_cap)
		else $error("capture flag survived acknowledge");

	property p_reserved_read;
		@(posedge mclk) disable iff (srst)
		(ce && rd_stb && (addr == OFF_MASK || addr == OFF_FLAGS))
			|=> (rdata & ~FLAG_MASK) == 8'h00;
	endproperty
	a_reserved_read: assert property (p_reserved_read)
		else $error("reserved bit read back as one");

endmodule : t1irq_ctrl

// *** bench/cpu_model.sv ***
/*
 * Core stand-in: drives the global interrupt enable and runs vectors.
 * Assumes per-source request levels from the flag block on mclk.
 */
`timescale 1ns/1ps
module cpu_model (
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic       gie,
	input  wire logic       auto_ack,
	input  wire logic [3:0] irq_req,
	output logic            global_irq_en,
	output logic      [3:0] vector_ack
);
	assign global_irq_en = gie;
	// One vector at a time, lowest source first; the idle cycle lets the request drop.
	always_ff @(posedge mclk) begin
		if (srst || vector_ack != 4'h0 || !auto_ack)
			vector_ack <= 4'h0;
		else
			vector_ack <= irq_req & (~irq_req + 4'h1);
	end
endmodule : cpu_model

// *** bench/t1irq_ctrl_tb.sv ***
/*
 * Self-checking bench for the timer flag block against a reference model.
 * Assumes cpu_model answers vectors on the same mclk.
 */
`timescale 1ns/1ps
module t1irq_ctrl_tb
	import t1irq_pkg::*;
;
	logic       mclk, srst, ce, wr_stb, rd_stb, gie, auto_ack, pin, gen, irq;
	logic       ovf, ma, mb, top, fa, fb;
	logic [3:0] addr, ack, irq_req;
	logic [7:0] wdata, rdata, mask_m, flags_m, stat_m, en_m;
	logic [3:0] modes [6] = '{4'h0, 4'h4, 4'h8, 4'hA, 4'hC, 4'hE};
	int         mismatches, n_compared;

	t1irq_ctrl uut (.mclk(mclk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .global_irq_en(gen),
		.ovf_evt(ovf), .match_a_evt(ma), .match_b_evt(mb), .top_evt(top),
		.force_match_a_strobe(fa), .force_match_b_strobe(fb), .capture_input_pin(pin),
		.vector_ack(ack), .irq_req(irq_req), .irq(irq));
	cpu_model cpu (.mclk(mclk), .srst(srst), .gie(gie), .auto_ack(auto_ack),
		.irq_req(irq_req), .global_irq_en(gen), .vector_ack(ack));

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: reg %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	// The level line follows the sticky bits in the same cycle; exact-cycle checks still leave it out.
	task automatic chk_req(input logic full);
		logic [4:0] e;
		e = {full & |(stat_m[3:0] & en_m[3:0]),
			{flags_m[5], flags_m[2:0]} & {mask_m[5], mask_m[2:0]} & {4{gie}}};
		n_compared++;
		if ({full & irq, irq_req} !== e) begin
			mismatches++;
			$display("mismatch at %0t: req %h expected %h", $time, {irq, irq_req}, e);
		end
	endtask : chk_req

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr   <= a;
		wdata  <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
		case (a)
			OFF_MASK:    mask_m  = d & FLAG_MASK;
			OFF_FLAGS:   flags_m = flags_m & ~d;
			OFF_IRQ_CLR: stat_m  = stat_m & ~d & 8'h0F;
			OFF_IRQ_EN:  en_m    = d & 8'h0F;
			default:     ;
		endcase
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1;
		chk_reg(rdata, exp);
	endtask : rd

	task automatic set_f(input int b);
		flags_m[b] = 1'b1;
		stat_m[(b == 5) ? 3 : b] = 1'b1;
	endtask : set_f

	task automatic pulse(input int k);
		@(posedge mclk);
		{ovf, ma, mb, top, fa, fb} <= 6'h20 >> k;
		@(posedge mclk);
		{ovf, ma, mb, top, fa, fb} <= 6'h00;
		#1;
	endtask : pulse

	task automatic settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask : settle

	// The pin is parked first under the old settings, so only the tested edge counts.
	task automatic cap(input logic sel, input logic [3:0] mode, input logic rise,
		input logic exp);
		@(posedge mclk);
		pin <= ~rise;
		repeat (6) @(posedge mclk);
		wr(OFF_CTRL, {mode, 3'h0, sel});
		wr(OFF_FLAGS, 8'hFF);
		wr(OFF_IRQ_CLR, 8'hFF);
		pin <= rise;
		repeat (6) @(posedge mclk);
		if (exp)
			set_f(BIT_CAPTURE);
		rd(OFF_FLAGS, flags_m);
	endtask : cap

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		#200000;
		mismatches++;
		results();
	end

	initial begin
		srst = 1'b1;
		{wr_stb, rd_stb, gie, auto_ack, ovf, ma, mb, top, fa, fb} = '0;
		pin = 1'b1;
		ce = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		{mask_m, flags_m, stat_m, en_m} = '0;
		mismatches = 0;
		n_compared = 0;
		void'($urandom(32'h1816e848));
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		for (int a = 0; a < 7; a++)
			rd((a == 6) ? 4'hF : 4'(a), 8'h00);
		wr(OFF_MASK, 8'hFF);
		wr(4'hF, 8'hFF);
		rd(OFF_MASK, 8'h27);
		rd(4'hF, 8'h00);
		for (int k = 0; k < 6; k++) begin
			wr(OFF_MASK, 8'($urandom()));
			wr(OFF_FLAGS, 8'hFF);
			wr(OFF_IRQ_CLR, 8'hFF);
			wr(OFF_IRQ_EN, 8'($urandom()));
			gie <= 1'($urandom());
			pulse(k);
			if (k == 0)
				set_f(BIT_OVF);
			chk_req(1'b0);
			@(posedge mclk);
			#1;
			if (k == 1 || k == 2)
				set_f(k);
			chk_req(1'b0);
			settle();
			chk_req(1'b1);
			rd(OFF_MASK, mask_m);
			rd(OFF_FLAGS, flags_m);
			rd(OFF_STATUS, stat_m);
		end
		foreach (modes[i]) begin
			wr(OFF_FLAGS, 8'hFF);
			wr(OFF_CTRL, {modes[i], 4'h0});
			pulse(3);
			if (modes[i] inside {WGM_CTC_ICR, WGM_FPWM_ICR, WGM_PC_ICR, WGM_PFC_ICR})
				set_f(BIT_CAPTURE);
			rd(OFF_FLAGS, flags_m);
		end
		cap(1'b0, WGM_NORMAL, 1'b0, 1'b1);
		cap(1'b0, WGM_NORMAL, 1'b1, 1'b0);
		cap(1'b1, WGM_NORMAL, 1'b1, 1'b1);
		cap(1'b1, WGM_NORMAL, 1'b0, 1'b0);
		cap(1'b0, WGM_CTC_ICR, 1'b0, 1'b0);
		wr(OFF_FLAGS, 8'hFF);
		wr(OFF_MASK, 8'h25);
		gie <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			pulse(k);
			set_f((k == 3) ? 5 : k);
		end
		wr(OFF_FLAGS, 8'h02);
		rd(OFF_FLAGS, flags_m);
		pulse(1);
		set_f(BIT_MATCH_A);
		auto_ack <= 1'b1;
		repeat (12) @(posedge mclk);
		auto_ack <= 1'b0;
		flags_m = flags_m & ~8'h25;
		rd(OFF_FLAGS, flags_m);
		@(posedge mclk);
		ovf    <= 1'b1;
		addr   <= OFF_FLAGS;
		wdata  <= 8'h01;
		wr_stb <= 1'b1;
		@(posedge mclk);
		ovf    <= 1'b0;
		wr_stb <= 1'b0;
		set_f(BIT_OVF);
		rd(OFF_FLAGS, flags_m);
		wr(OFF_IRQ_EN, 8'h00);
		settle();
		chk_req(1'b1);
		wr(OFF_IRQ_EN, 8'h01);
		settle();
		chk_req(1'b1);
		wr(OFF_IRQ_CLR, 8'h01);
		settle();
		chk_req(1'b1);
		rd(OFF_IRQ_EN, en_m);
		// An event that arrives while the enable is low must leave no trace.
		wr(OFF_FLAGS, 8'h01);
		ce <= 1'b0;
		pulse(0);
		ce <= 1'b1;
		rd(OFF_FLAGS, flags_m);
		rd(OFF_STATUS, stat_m);
		// A second reset in mid-run must bring the mask, flag and status registers and every request back to zero.
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		{mask_m, flags_m, stat_m, en_m} = '0;
		rd(OFF_MASK, mask_m);
		rd(OFF_FLAGS, flags_m);
		rd(OFF_STATUS, stat_m);
		chk_req(1'b1);
		results();
	end
endmodule : t1irq_ctrl_tb
